// ===== rtl/fsp_ctrl.sv
`timescale 1ns/100ps
module fsp_ctrl
	import fsp_pkg::*;
(
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// special function register port
	input wire fsp_sfr_req_t sfr,
	output logic [7:0] sfr_rdata,
	// cpu context
	input wire logic cpu_in_loader,
	input wire logic [15:0] cpu_pc,
	output logic [15:0] fetch_addr,
	output logic cpu_stall,
	output logic irq_hold,
	// boot and reset
	input wire logic power_up,
	input wire logic hw_boot_select,
	input wire logic hw_boot_select_alt,
	output logic boot_loader,
	output logic soft_reset,
	// voltage guard
	input wire logic low_voltage_write_guard,
	input wire logic supply_low,
	// flash array port
	output fsp_flash_req_t flash,
	input wire logic [7:0] flash_rdata
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] self_prog_control;   // enable, boot select, timing
	logic [2:0] flash_op_mode;   // operation select
	logic [7:0] flash_addr_high;
	logic [7:0] flash_addr_low;
	logic [7:0] flash_data;
	fsp_state_t state;
	logic [15:0] cur_addr;   // walks the page on erase
	logic [2:0] op;   // latched mode
	logic trig;
	logic tmr_busy;
	logic tmr_start;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire wr_ctrl = sfr.wr && (sfr.addr == OFS_CTRL);
	wire wr_mode = sfr.wr && (sfr.addr == OFS_MODE);
	wire wr_ah = sfr.wr && (sfr.addr == OFS_ADDR_HIGH);
	wire wr_al = sfr.wr && (sfr.addr == OFS_ADDR_LOW);
	wire wr_data = sfr.wr && (sfr.addr == OFS_DATA);
	wire wr_cmd = sfr.wr && (sfr.addr == OFS_CMD);
	wire [15:0] tgt = {flash_addr_high, flash_addr_low};
	wire ena = self_prog_control[CTRL_ENABLE_BIT];
	wire [2:0] timing = self_prog_control[2:0];
	// application code reaches only the data region; the loader reaches up to its end
	wire addr_ok = (tgt <= LAST_DATA_ADDR) && (cpu_in_loader || tgt >= DATA_REGION_START);
	wire is_write = (flash_op_mode == MODE_PROGRAM) || (flash_op_mode == MODE_ERASE);
	wire volt_block = low_voltage_write_guard && supply_low && is_write;
	wire mode_ok = (flash_op_mode != MODE_STANDBY) && !flash_op_mode[2];
	wire go = trig && ena && addr_ok && mode_ok && !volt_block;
	// slower oscillators need fewer cycles; scale by shifting down with the timing band
	wire [15:0] base_len = (flash_op_mode == MODE_READ) ? 16'(READ_CYC) :
		(flash_op_mode == MODE_PROGRAM) ? 16'(PROG_CYC) : 16'(ERASE_CYC);
	wire [15:0] scaled_len = base_len >> timing;
	wire [15:0] op_len = (scaled_len == 16'h0000) ? 16'h0001 : scaled_len;
	// erase walks the page offset and wraps back to the base after the last byte
	wire [15:0] next_in_page = (cur_addr & PAGE_MASK) | ((cur_addr + 16'h0001) & ~PAGE_MASK);
	wire page_wrapped = (cur_addr & ~PAGE_MASK) == 16'h0000;
	wire [7:0] rd_mux = (sfr.addr == OFS_CTRL) ? (self_prog_control & CTRL_RD_MASK) :
		(sfr.addr == OFS_MODE) ? {5'h00, flash_op_mode} :
		(sfr.addr == OFS_ADDR_HIGH) ? flash_addr_high :
		(sfr.addr == OFS_ADDR_LOW) ? flash_addr_low :
		(sfr.addr == OFS_DATA) ? flash_data : 8'h00;   // command register reads zero
	wire boot_pick = hw_boot_select || hw_boot_select_alt;
	wire sr_fire = wr_ctrl && sfr.wdata[CTRL_SOFT_RST_BIT];
	wire [15:0] next_fetch = cpu_in_loader ? (cpu_pc + LOADER_START) : cpu_pc;
	wire next_stall = go || (state != ST_IDLE && state != ST_DONE);

	// ----------------------------------------
	// key sequencer and busy timer
	// ----------------------------------------
	fsp_unlock u_unlock (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.cmd_wr(wr_cmd),
		.cmd_data(sfr.wdata),
		.trig(trig)
	);

	assign tmr_start = (state == ST_START) || (state == ST_ERASE && !tmr_busy && !page_wrapped);

	fsp_timer u_timer (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.start(tmr_start),
		.len(op_len),
		.busy(tmr_busy)
	);

	// ----------------------------------------
	// register writes; writes are ignored while an operation runs
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			self_prog_control <= RST_CTRL;
			flash_op_mode <= RST_MODE;
			flash_addr_high <= RST_ADDR;
			flash_addr_low <= RST_ADDR;
		end else if (ce && state == ST_IDLE) begin
			if (wr_ctrl) begin
				// soft reset bit self-clears
				self_prog_control <= sfr.wdata & ~(8'h01 << CTRL_SOFT_RST_BIT);
			end
			if (wr_mode) begin
				flash_op_mode <= sfr.wdata[2:0];
			end
			if (wr_ah) begin
				flash_addr_high <= sfr.wdata;
			end
			if (wr_al) begin
				flash_addr_low <= sfr.wdata;
			end
		end
	end

	// ----------------------------------------
	// data register: cpu writes, read result capture
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flash_data <= RST_DATA;
		end else if (ce) begin
			if (state == ST_RUN && !tmr_busy && op == MODE_READ) begin
				flash_data <= flash_rdata;
			end else if (wr_data && state == ST_IDLE) begin
				flash_data <= sfr.wdata;
			end
		end
	end

	// ----------------------------------------
	// operation sequencer
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			cur_addr <= 16'h0000;
			op <= RST_MODE;
		end else if (ce) begin
			case (state)
				ST_IDLE: begin
					if (go) begin
						op <= flash_op_mode;
						// erase starts at the page base whatever low bits were loaded
						cur_addr <= (flash_op_mode == MODE_ERASE) ? (tgt & PAGE_MASK) : tgt;
						state <= ST_START;
					end
				end
				ST_START: begin
					state <= (op == MODE_ERASE) ? ST_ERASE : ST_RUN;
					if (op == MODE_ERASE) begin
						// the page base byte is written in this slot
						cur_addr <= next_in_page;
					end
				end
				ST_ERASE: begin
					// one timed slot per byte of the 512-byte page; the wrap marks the end
					if (!tmr_busy && page_wrapped) begin
						state <= ST_DONE;
					end else if (tmr_start) begin
						cur_addr <= next_in_page;
					end
				end
				ST_RUN: begin
					if (!tmr_busy) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// flash strobes and cpu side outputs
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flash <= '0;
			sfr_rdata <= 8'h00;
			cpu_stall <= 1'b0;
			irq_hold <= 1'b0;
			fetch_addr <= 16'h0000;
		end else if (ce) begin
			flash.rd <= (state == ST_START) && (op == MODE_READ);
			flash.wr <= ((state == ST_START) && (op == MODE_PROGRAM)) || (tmr_start && (op == MODE_ERASE));
			flash.addr <= (state == ST_ERASE) ? cur_addr : cur_addr;
			flash.wdata <= (op == MODE_ERASE) ? 8'hff : flash_data;
			sfr_rdata <= rd_mux;
			cpu_stall <= next_stall;
			irq_hold <= next_stall;
			fetch_addr <= next_fetch;
		end
	end

	// ----------------------------------------
	// boot region and software reset
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_loader <= 1'b0;
			soft_reset <= 1'b0;
		end else if (ce) begin
			soft_reset <= sr_fire && state == ST_IDLE;
			if (power_up) begin
				boot_loader <= boot_pick;
			end else if (sr_fire && state == ST_IDLE) begin
				boot_loader <= sfr.wdata[CTRL_BOOT_SEL_BIT];
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence key_seq;
		ce && wr_cmd && sfr.wdata == KEY_FIRST ##1 ce && wr_cmd && sfr.wdata == KEY_SECOND;
	endsequence

	// a first byte while already armed is a stray write, so the key must start disarmed
	key_start_a: assert property (@(posedge clk) disable iff (rst)
		!u_unlock.armed ##0 key_seq |=> trig)
		else $error("key did not trigger");
	stray_key_a: assert property (@(posedge clk) disable iff (rst)
		ce && $past(ce) && trig |-> $past(wr_cmd) && $past(sfr.wdata) == KEY_SECOND)
		else $error("trigger without second key");
	no_enable_a: assert property (@(posedge clk) disable iff (rst)
		ce && state == ST_IDLE && !ena |=> state == ST_IDLE || !$past(ce))
		else $error("operation without enable");
	bad_addr_a: assert property (@(posedge clk) disable iff (rst)
		ce && state == ST_IDLE && tgt > LAST_DATA_ADDR |=> state == ST_IDLE || !$past(ce))
		else $error("out-of-range trigger accepted");
	stall_busy_a: assert property (@(posedge clk) disable iff (rst)
		ce && state == ST_RUN |=> cpu_stall || !$past(ce))
		else $error("cpu not stalled during operation");
	read_back_a: assert property (@(posedge clk) disable iff (rst)
		ce && state == ST_RUN && !tmr_busy && op == MODE_READ |=> flash_data == $past(flash_rdata))
		else $error("read data not captured");
	volt_block_a: assert property (@(posedge clk) disable iff (rst)
		ce && state == ST_IDLE && volt_block |=> state == ST_IDLE)
		else $error("write allowed at low supply");
	boot_pick_a: assert property (@(posedge clk) disable iff (rst)
		ce && power_up |=> boot_loader == $past(boot_pick))
		else $error("power-up boot region wrong");

endmodule

// ===== rtl/fsp_pkg.sv
package fsp_pkg;

	// ----------------------------------------
	// register offsets (special function register space)
	// ----------------------------------------
	localparam logic [7:0] OFS_DATA = 8'he2;   // flash_data
	localparam logic [7:0] OFS_ADDR_HIGH = 8'he3;   // flash_addr_high
	localparam logic [7:0] OFS_ADDR_LOW = 8'he4;   // flash_addr_low
	localparam logic [7:0] OFS_MODE = 8'he5;   // flash_op_mode
	localparam logic [7:0] OFS_CMD = 8'he6;   // flash_trigger_command
	localparam logic [7:0] OFS_CTRL = 8'he7;   // self_prog_control

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int CTRL_ENABLE_BIT = 7;
	localparam int CTRL_BOOT_SEL_BIT = 6;
	localparam int CTRL_SOFT_RST_BIT = 5;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_ADDR = 8'h00;
	localparam logic [2:0] RST_MODE = 3'h0;
	localparam logic [7:0] CTRL_RD_MASK = 8'he7;   // bits 4..3 read as zero

	// ----------------------------------------
	// trigger key and modes
	// ----------------------------------------
	localparam logic [7:0] KEY_FIRST = 8'h46;
	localparam logic [7:0] KEY_SECOND = 8'hb9;

	typedef enum logic [2:0] {
		MODE_STANDBY = 3'b000,
		MODE_READ = 3'b001,
		MODE_PROGRAM = 3'b010,
		MODE_ERASE = 3'b011
	} fsp_mode_t;

	// ----------------------------------------
	// memory layout
	// ----------------------------------------
	localparam logic [15:0] PAGE_MASK = 16'hfe00;   // 512-byte pages
	localparam logic [15:0] LAST_DATA_ADDR = 16'hf7ff;   // last byte of the data region, just below loader memory
	localparam logic [15:0] DATA_REGION_START = 16'hf000;   // first byte of the data region
	localparam logic [15:0] LOADER_START = 16'hf800;   // loader memory start offset
	localparam logic [15:0] FLASH_BYTES_M1 = 16'hffff;

	// ----------------------------------------
	// timing: base flash busy times per operation
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int READ_TIME_NS = 80;
	localparam int PROG_TIME_NS = 800;
	localparam int ERASE_TIME_NS = 3200;
	localparam int READ_CYC = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fsp_sfr_req_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} fsp_flash_req_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_ERASE = 3'b010,
		ST_RUN = 3'b011,
		ST_DONE = 3'b100
	} fsp_state_t;

endpackage

// ===== rtl/fsp_unlock.sv
`timescale 1ns/100ps
module fsp_unlock
	import fsp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// command writes
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_data,
	// one-cycle trigger when the two-write key is complete
	output logic trig
);

	logic armed;   // first key byte seen

	// ----------------------------------------
	// key sequencer
	// ----------------------------------------
	// any stray write drops the half-finished key, so a lone second byte never fires
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			armed <= 1'b0;
			trig <= 1'b0;
		end else if (ce) begin
			trig <= cmd_wr && armed && (cmd_data == KEY_SECOND);
			if (cmd_wr) begin
				armed <= !armed && (cmd_data == KEY_FIRST);
			end
		end
	end

endmodule

// ===== rtl/fsp_timer.sv
`timescale 1ns/100ps
module fsp_timer
	import fsp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// start with a length in cycles
	input wire logic start,
	input wire logic [15:0] len,
	// level high while counting
	output logic busy
);

	logic [15:0] cnt;   // remaining cycles

	// ----------------------------------------
	// down counter
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 16'h0000;
			busy <= 1'b0;
		end else if (ce) begin
			if (start) begin
				cnt <= len;
				busy <= 1'b1;
			end else if (cnt > 16'h0001) begin
				cnt <= cnt - 16'h0001;
			end else begin
				cnt <= 16'h0000;
				busy <= 1'b0;
			end
		end
	end

endmodule

// ===== tb/flash_self_programming_ctrl_tb_top.sv
`timescale 1ns/100ps
module flash_self_programming_ctrl_tb_top
	import fsp_pkg::*;
;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'b0; // 125 mhz system clock
	logic rst = 1'b1; // asynchronous reset, active high
	logic ce = 1'b1; // clock enable, dropped once to test a frozen write
	fsp_sfr_req_t sfr = '0; // register request
	logic [7:0] sfr_rdata;
	logic cpu_in_loader = 1'b0;
	logic [15:0] cpu_pc = 16'h0000;
	logic [15:0] fetch_addr;
	logic cpu_stall;
	logic irq_hold;
	logic power_up = 1'b0;
	logic hw_boot_select = 1'b0;
	logic hw_boot_select_alt = 1'b0;
	logic boot_loader;
	logic soft_reset;
	logic low_voltage_write_guard = 1'b0;
	logic supply_low = 1'b0;
	fsp_flash_req_t flash;
	logic [7:0] flash_rdata = 8'h00;
	int num_errors = 0; // mismatches seen
	int checks = 0; // comparisons made
	int n_rd = 0; // array read pulses
	int n_wr = 0; // array write pulses
	int n_bad = 0; // array writes outside the page or not 0xff
	logic [15:0] last_addr = 16'h0000;
	logic [7:0] last_data = 8'h00;
	logic [15:0] page = 16'h0000; // page under erase

	// ----------------------------------------
	// clock and design
	// ----------------------------------------
	always #4 clk = ~clk;

	fsp_ctrl uut (
		.clk(clk), .rst(rst), .ce(ce), .sfr(sfr), .sfr_rdata(sfr_rdata),
		.cpu_in_loader(cpu_in_loader), .cpu_pc(cpu_pc), .fetch_addr(fetch_addr),
		.cpu_stall(cpu_stall), .irq_hold(irq_hold), .power_up(power_up),
		.hw_boot_select(hw_boot_select), .hw_boot_select_alt(hw_boot_select_alt),
		.boot_loader(boot_loader), .soft_reset(soft_reset),
		.low_voltage_write_guard(low_voltage_write_guard), .supply_low(supply_low),
		.flash(flash), .flash_rdata(flash_rdata)
	);

	// ----------------------------------------
	// flash array stand-in
	// ----------------------------------------
	// answers a read with a byte derived from the address, so a stale value shows
	always @(posedge clk) begin
		if (flash.rd === 1'b1) begin
			n_rd <= n_rd + 1;
			last_addr <= flash.addr;
			flash_rdata <= flash.addr[7:0] ^ 8'h5a;
		end
		if (flash.wr === 1'b1) begin
			n_wr <= n_wr + 1;
			last_addr <= flash.addr;
			last_data <= flash.wdata;
			if ((flash.addr & PAGE_MASK) !== page || flash.wdata !== 8'hff) begin
				n_bad <= n_bad + 1;
			end
		end
	end

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (num_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// watchdog: the whole run needs well under 20k cycles
	initial begin
		#400000;
		num_errors++;
		tally_and_finish();
	end

	// ----------------------------------------
	// register access tasks
	// ----------------------------------------
	// requests stay up into the next call so no signal is assigned twice per edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
	endtask

	task automatic idle();
		@(posedge clk);
		sfr <= '0;
	endtask

	// read data is registered, so it is taken one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		sfr <= '0;
		#1;
		d = sfr_rdata;
	endtask

	// loads the registers, sends the key, and follows the stall
	task automatic op(input logic [7:0] ctl, input logic [7:0] md, input logic [15:0] a,
		input logic [7:0] d, input logic run);
		int n;
		logic seen;
		wr(OFS_CTRL, ctl);
		wr(OFS_MODE, md);
		wr(OFS_ADDR_HIGH, a[15:8]);
		wr(OFS_ADDR_LOW, a[7:0]);
		wr(OFS_DATA, d);
		wr(OFS_CMD, KEY_FIRST);
		wr(OFS_CMD, KEY_SECOND);
		idle();
		seen = 1'b0;
		for (n = 0; n < 6 && !seen; n++) begin
			@(posedge clk);
			#1;
			if (cpu_stall === 1'b1) seen = 1'b1;
		end
		check(16'(seen), 16'(run), "stall after key");
		if (seen) begin
			check(16'(irq_hold), 16'h0001, "irq hold during stall");
			n = 0;
			while (cpu_stall !== 1'b0 && n < 20000) begin
				@(posedge clk);
				#1;
				n++;
			end
			check(16'(cpu_stall), 16'h0000, "stall released");
			check(16'(irq_hold), 16'h0000, "irq hold released");
		end
	endtask

	// writes the control register with the soft reset bit and waits for the pulse
	task automatic sreset(input logic [7:0] ctl, input logic exp_boot);
		int n;
		logic seen;
		wr(OFS_CTRL, ctl);
		idle();
		seen = 1'b0;
		// the pulse stands for the cycle right after the write edge
		for (n = 0; n < 4; n++) begin
			#1;
			if (soft_reset === 1'b1) seen = 1'b1;
			@(posedge clk);
		end
		#1;
		check(16'(seen), 16'h0001, "soft reset pulse");
		check(16'(boot_loader), 16'(exp_boot), "soft reset boot region");
	endtask

	// power-up with a given pair of boot options
	task automatic pwr(input logic h1, input logic h2, input logic exp_boot);
		@(posedge clk);
		hw_boot_select <= h1;
		hw_boot_select_alt <= h2;
		power_up <= 1'b1;
		@(posedge clk);
		power_up <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(16'(boot_loader), 16'(exp_boot), "power-up boot region");
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] d;
		int base;
		int bad0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// reset values and access kinds
		rd(OFS_DATA, d);
		check(16'(d), 16'(RST_DATA), "data reset value");
		rd(OFS_CMD, d);
		check(16'(d), 16'h0000, "command reads zero");
		rd(8'h10, d);
		check(16'(d), 16'h0000, "unmapped read");
		wr(OFS_DATA, 8'ha5);
		idle();
		rd(OFS_DATA, d);
		check(16'(d), 16'h00a5, "data register read back");
		// a write offered while the clock enable is low must not land
		@(posedge clk);
		ce <= 1'b0;
		wr(OFS_DATA, 8'h77);
		idle();
		ce <= 1'b1;
		rd(OFS_DATA, d);
		check(16'(d), 16'h00a5, "write frozen by clock enable");
		wr(OFS_CTRL, 8'h9b);
		idle();
		rd(OFS_CTRL, d);
		check(16'(d), 16'h0083, "control read back");
		// byte read, boundary of the data region
		base = n_rd;
		op(8'h80, 8'h01, 16'hf000, 8'h00, 1'b1);
		check(16'(n_rd - base), 16'h0001, "one array read");
		check(last_addr, 16'hf000, "read address");
		rd(OFS_DATA, d);
		check(16'(d), 16'h005a, "read result in data register");
		op(8'h80, 8'h01, 16'hf7ff, 8'h00, 1'b1);
		rd(OFS_DATA, d);
		check(16'(d), 16'h00a5, "read of last byte");
		// byte program
		base = n_wr;
		page = 16'hf200;
		op(8'h80, 8'h02, 16'hf2c3, 8'h3c, 1'b1);
		check(16'(n_wr - base), 16'h0001, "one array write");
		check(last_addr, 16'hf2c3, "program address");
		check(16'(last_data), 16'h003c, "program data");
		// page erase with the shortest timing, address inside the page
		base = n_wr;
		page = 16'hf400;
		bad0 = n_bad;
		op(8'h87, 8'h03, 16'hf4a7, 8'h00, 1'b1);
		check(16'(n_wr - base), 16'd512, "erase byte count");
		check(16'(n_bad - bad0), 16'h0000, "erase writes 0xff inside page");
		// triggers that must be voided, and a read that still runs at low supply
		base = n_rd + n_wr;
		op(8'h80, 8'h01, 16'hf800, 8'h00, 1'b0);
		op(8'h00, 8'h01, 16'hf010, 8'h00, 1'b0);
		op(8'h80, 8'h00, 16'hf010, 8'h00, 1'b0);
		op(8'h80, 8'h04, 16'hf010, 8'h00, 1'b0);
		op(8'h80, 8'h02, 16'h0100, 8'h11, 1'b0);
		low_voltage_write_guard <= 1'b1;
		supply_low <= 1'b1;
		op(8'h80, 8'h02, 16'hf020, 8'h11, 1'b0);
		op(8'h87, 8'h03, 16'hf600, 8'h00, 1'b0);
		op(8'h80, 8'h01, 16'hf020, 8'h00, 1'b1);
		low_voltage_write_guard <= 1'b0;
		supply_low <= 1'b0;
		base = base + 1;
		// broken key sequences
		wr(OFS_CMD, KEY_FIRST);
		wr(OFS_CMD, 8'h12);
		wr(OFS_CMD, KEY_SECOND);
		wr(OFS_CMD, KEY_FIRST);
		wr(OFS_CMD, KEY_FIRST);
		wr(OFS_CMD, KEY_SECOND);
		idle();
		repeat (6) @(posedge clk);
		#1;
		check(16'(cpu_stall), 16'h0000, "broken key ignored");
		check(16'(n_rd + n_wr - base), 16'h0000, "no array access on void");
		// loader code: address translation and full reach
		cpu_in_loader <= 1'b1;
		cpu_pc <= 16'h0123;
		repeat (2) @(posedge clk);
		#1;
		check(fetch_addr, 16'hf923, "loader fetch offset");
		page = 16'h0000;
		op(8'h80, 8'h02, 16'h0100, 8'h00, 1'b1);
		cpu_in_loader <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(fetch_addr, 16'h0123, "application fetch untranslated");
		// boot region selection
		pwr(1'b1, 1'b0, 1'b1);
		pwr(1'b0, 1'b1, 1'b1);
		sreset(8'h20, 1'b0);
		pwr(1'b0, 1'b0, 1'b0);
		sreset(8'h60, 1'b1);
		tally_and_finish();
	end
endmodule
